// ### pmic_irq_params.svh
`ifndef PMIC_IRQ_PARAMS_SVH
`define PMIC_IRQ_PARAMS_SVH
`define ADDR_FLAGS_BASE 8'h00
`define ADDR_MASKS_BASE 8'h04
`define ADDR_LEVELS_BASE 8'h08
`define ADDR_RISE_EN 8'h0c
`define ADDR_FALL_EN 8'h0d
`define ADDR_INT_CTRL 8'h0e
`define ADDR_SLEEP_CFG 8'h0f
`define ADDR_HOLD_DELAY 8'h10
`define ADDR_NONE 8'hff
`define RST_MASKS 8'h00
`define RST_RISE_EN 8'h00
`define RST_FALL_EN 8'h00
`define RST_INT_CTRL 3'h0
`define RST_SLEEP_CFG 1'b0
`define RST_HOLD_DELAY 2'h0
`define G1_HOLD_BIT 2
`define G1_BTN_BIT 1
`define G1_EDGE_RISE 8'h72
`define G1_EDGE_FALL 8'h70
`define G2_EDGE_RISE 8'h70
`define G3_EDGE_RISE 8'hff
`define CLK_MHZ 100
`define HOLD_BASE_MS 1000
`endif

// ### pmic_irq_pkg.sv
package pmic_irq_pkg;
   // Control word: pending storage, clear method, line polarity
   typedef struct packed {
      logic pending_en;
      logic clear_on_write;
      logic active_high;
   } int_ctrl_t;
   typedef logic [7:0] byte_t;
endpackage

// ### pmic_interrupt_controller.sv
`timescale 1ns/1ps
`include "pmic_irq_params.svh"
module pmic_interrupt_controller #(
   parameter int unsigned HOLD_BASE_CYCLES = `HOLD_BASE_MS * `CLK_MHZ * 1000
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   input wire logic supply_monitor_event_in,
   input wire logic die_overheat_event_in,
   input wire logic powerdown_pin_event_in,
   input wire logic power_button_n_in,
   input wire logic device_on_in,
   input wire logic sleep_state_in,
   input wire logic short_event_in,
   input wire logic first_supply_event_in,
   input wire logic reset_pin_event_in,
   input wire logic [7:0] group_three_events_in,
   input wire logic [7:0] gpio_levels_in,
   input wire logic [7:0] gpio_primary_in,
   output logic irq_out,
   output logic on_request_out
);
   localparam int SYNC_W = 23;

   function automatic logic [7:0] edge_ev(input logic [7:0] prev, input logic [7:0] cur,
                                          input logic [7:0] rise, input logic [7:0] fall);
      edge_ev = (~prev & cur & rise) | (prev & ~cur & fall);
   endfunction

   function automatic logic is_addr(input logic [7:0] a, input logic [7:0] base,
                                    input logic [1:0] idx);
      is_addr = (a == (base + {6'h00, idx}));
   endfunction

   logic [SYNC_W-1:0] s1_q;
   logic [SYNC_W-1:0] s2_q;
   logic [SYNC_W-1:0] raw;
   logic [7:0] lc [4];
   logic [7:0] lp_q [4];
   logic [7:0] ev [4];
   logic [7:0] evm [4];
   logic [7:0] clr [4];
   logic [7:0] flags_q [4];
   logic [7:0] pend_q [4];
   logic [7:0] mask_q [4];
   logic [7:0] rise_q;
   logic [7:0] fall_q;
   pmic_irq_pkg::int_ctrl_t ctrl_q;
   logic sleep_mask_q;
   logic [1:0] hold_q;
   logic [31:0] hold_cnt_q;
   logic [31:0] hold_thr;
   logic hold_hit;
   logic hold_live;
   logic btn_low;
   logic [7:0] last_addr_q;
   logic acc_same;
   logic irq_active;
   logic irq_asserted;
   logic [7:0] read_val;
   logic [7:0] rdata_q;
   logic irq_q;
   logic on_req_q;

   assign raw = {gpio_levels_in, group_three_events_in, supply_monitor_event_in,
                 die_overheat_event_in, powerdown_pin_event_in, ~power_button_n_in,
                 short_event_in, first_supply_event_in, reset_pin_event_in};

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
      end
   end

   assign btn_low = s2_q[3];
   assign hold_thr = HOLD_BASE_CYCLES * ({30'h0, hold_q} + 32'h1);
   assign hold_live = btn_low && (hold_cnt_q == hold_thr);
   assign hold_hit = btn_low && (hold_cnt_q == hold_thr - 32'h1);

   // Long hold timer, restarts on release
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         hold_cnt_q <= 32'h0;
      end else if (!btn_low) begin
         hold_cnt_q <= 32'h0;
      end else if (hold_cnt_q != hold_thr) begin
         hold_cnt_q <= hold_cnt_q + 32'h1;
      end
   end

   // Live levels of each source line
   always_comb begin
      lc[0] = {1'b0, s2_q[6], s2_q[5], s2_q[4], 1'b0, hold_live, btn_low, 1'b0};
      lc[1] = {1'b0, s2_q[2], s2_q[1], s2_q[0], 4'h0};
      lc[2] = s2_q[14:7];
      lc[3] = s2_q[22:15];
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         for (int g = 0; g < 4; g++) begin
            lp_q[g] <= 8'h00;
         end
      end else begin
         for (int g = 0; g < 4; g++) begin
            lp_q[g] <= lc[g];
         end
      end
   end

   // Edge events of all four groups; group one hold and button override
   always_comb begin
      ev[0] = edge_ev(lp_q[0], lc[0], `G1_EDGE_RISE, `G1_EDGE_FALL);
      // Button press counts only while on
      ev[0][`G1_BTN_BIT] = ev[0][`G1_BTN_BIT] & device_on_in;
      ev[0][`G1_HOLD_BIT] = hold_hit;
      ev[1] = edge_ev(lp_q[1], lc[1], `G2_EDGE_RISE, 8'h00);
      ev[2] = edge_ev(lp_q[2], lc[2], `G3_EDGE_RISE, 8'h00);
      ev[3] = edge_ev(lp_q[3], lc[3], rise_q & gpio_primary_in, fall_q & gpio_primary_in);
   end

   // Any access counts as the intervening one between two clears
   assign acc_same = (addr_in == last_addr_q);

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         last_addr_q <= `ADDR_NONE;
      end else if (rd_in || wr_in) begin
         last_addr_q <= addr_in;
      end
   end

   assign irq_active = |{flags_q[0], flags_q[1], flags_q[2], flags_q[3]};

   // Per-group flag, pending and mask state
   for (genvar gi = 0; gi < 4; gi++) begin : g_grp
      logic [7:0] flag_left;
      logic hit_flag;

      assign hit_flag = is_addr(addr_in, `ADDR_FLAGS_BASE, 2'(gi)) && !acc_same;
      assign clr[gi] = !hit_flag ? 8'h00 :
                       ctrl_q.clear_on_write ? (wr_in ? wdata_in : 8'h00) :
                       (rd_in ? 8'hff : 8'h00);
      assign evm[gi] = ev[gi] & ~mask_q[gi];
      // A clear takes the pending level first
      assign flag_left = flags_q[gi] & ~(clr[gi] & ~pend_q[gi]);

      // New source flagged at once, set beats clear
      // Masked flag keeps its value until cleared
      always_ff @(posedge clk_in or posedge reset_in) begin
         if (reset_in) begin
            flags_q[gi] <= 8'h00;
         end else begin
            flags_q[gi] <= flag_left | evm[gi];
         end
      end

      // Repeat held as one pending event
      // Repeat dropped when pending storage is off
      always_ff @(posedge clk_in or posedge reset_in) begin
         if (reset_in) begin
            pend_q[gi] <= 8'h00;
         end else if (ctrl_q.pending_en && irq_active) begin
            pend_q[gi] <= (pend_q[gi] & ~clr[gi]) | (evm[gi] & flag_left);
         end else begin
            pend_q[gi] <= pend_q[gi] & ~clr[gi];
         end
      end

      always_ff @(posedge clk_in or posedge reset_in) begin
         if (reset_in) begin
            mask_q[gi] <= `RST_MASKS;
         end else if (wr_in && is_addr(addr_in, `ADDR_MASKS_BASE, 2'(gi))) begin
            mask_q[gi] <= wdata_in;
         end
      end
   end

   // Polarity, clear method, pending storage, sleep mask, hold delay and edge enables
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         ctrl_q <= `RST_INT_CTRL;
         sleep_mask_q <= `RST_SLEEP_CFG;
         hold_q <= `RST_HOLD_DELAY;
         rise_q <= `RST_RISE_EN;
         fall_q <= `RST_FALL_EN;
      end else if (wr_in) begin
         if (addr_in == `ADDR_INT_CTRL) begin
            ctrl_q <= pmic_irq_pkg::int_ctrl_t'(wdata_in[2:0]);
         end
         if (addr_in == `ADDR_SLEEP_CFG) begin
            sleep_mask_q <= wdata_in[0];
         end
         if (addr_in == `ADDR_HOLD_DELAY) begin
            hold_q <= wdata_in[1:0];
         end
         if (addr_in == `ADDR_RISE_EN) begin
            rise_q <= wdata_in;
         end
         if (addr_in == `ADDR_FALL_EN) begin
            fall_q <= wdata_in;
         end
      end
   end

   always_comb begin
      read_val = 8'h00;
      for (int g = 0; g < 4; g++) begin
         if (is_addr(addr_in, `ADDR_FLAGS_BASE, 2'(g))) begin
            read_val = flags_q[g];
         end
         if (is_addr(addr_in, `ADDR_MASKS_BASE, 2'(g))) begin
            read_val = mask_q[g];
         end
         if (is_addr(addr_in, `ADDR_LEVELS_BASE, 2'(g))) begin
            read_val = lc[g];
         end
      end
      if (addr_in == `ADDR_RISE_EN) begin
         read_val = rise_q;
      end
      if (addr_in == `ADDR_FALL_EN) begin
         read_val = fall_q;
      end
      if (addr_in == `ADDR_INT_CTRL) begin
         read_val = {5'h00, ctrl_q};
      end
      if (addr_in == `ADDR_SLEEP_CFG) begin
         read_val = {7'h00, sleep_mask_q};
      end
      if (addr_in == `ADDR_HOLD_DELAY) begin
         read_val = {6'h00, hold_q};
      end
   end

   // Data valid only in the cycle after the read strobe
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rd_in ? read_val : 8'h00;
      end
   end

   assign irq_asserted = irq_active && !(sleep_state_in && sleep_mask_q);

   // Inactive when every flag is clear, or in sleep state with the sleep mask set
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         irq_q <= 1'b1;
      end else begin
         irq_q <= ctrl_q.active_high ? irq_asserted : !irq_asserted;
      end
   end

   // Button press requests switch-on regardless of mask
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         on_req_q <= 1'b0;
      end else begin
         on_req_q <= irq_active || btn_low;
      end
   end

   assign rdata_out = rdata_q;
   assign irq_out = irq_q;
   assign on_request_out = on_req_q;

   property p_mask_blocks;
      @(posedge clk_in) disable iff (reset_in)
      (mask_q[0] & ~flags_q[0]) != 8'h00 |=>
         (flags_q[0] & $past(mask_q[0] & ~flags_q[0])) == 8'h00;
   endproperty
   a_mask_blocks: assert property (p_mask_blocks) else $error("masked flag set");

   property p_idle_level;
      @(posedge clk_in) disable iff (reset_in)
      !irq_active |=> irq_out == !$past(ctrl_q.active_high);
   endproperty
   a_idle_level: assert property (p_idle_level) else $error("line active with no flags");

   property p_active_level;
      @(posedge clk_in) disable iff (reset_in)
      (irq_active && !sleep_state_in) |=> irq_out == $past(ctrl_q.active_high);
   endproperty
   a_active_level: assert property (p_active_level) else $error("line not active");

   property p_read_clear;
      @(posedge clk_in) disable iff (reset_in)
      (rd_in && !ctrl_q.clear_on_write && addr_in == `ADDR_FLAGS_BASE && !acc_same
       && pend_q[0] == 8'h00) |=> (flags_q[0] & ~$past(evm[0])) == 8'h00;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("read did not clear");

   property p_read_other;
      @(posedge clk_in) disable iff (reset_in)
      (rd_in && addr_in == `ADDR_FLAGS_BASE) |=>
         (flags_q[1] & $past(flags_q[1])) == $past(flags_q[1]);
   endproperty
   a_read_other: assert property (p_read_other) else $error("other group cleared");

   property p_write_clear;
      @(posedge clk_in) disable iff (reset_in)
      (wr_in && ctrl_q.clear_on_write && addr_in == `ADDR_FLAGS_BASE + 8'h01 && !acc_same
       && pend_q[1] == 8'h00) |=>
         (flags_q[1] & $past(wdata_in) & ~$past(evm[1])) == 8'h00 &&
         (flags_q[1] & $past(flags_q[1] & ~wdata_in)) == $past(flags_q[1] & ~wdata_in);
   endproperty
   a_write_clear: assert property (p_write_clear) else $error("write clear wrong bits");

   property p_pending_hold;
      @(posedge clk_in) disable iff (reset_in)
      (ctrl_q.pending_en && irq_active && clr[3] == 8'h00 && (evm[3] & flags_q[3]) != 8'h00)
      |=> (pend_q[3] & $past(evm[3] & flags_q[3])) == $past(evm[3] & flags_q[3]);
   endproperty
   a_pending_hold: assert property (p_pending_hold) else $error("repeat not pending");

   property p_no_pending;
      @(posedge clk_in) disable iff (reset_in)
      !ctrl_q.pending_en |=> (pend_q[3] & ~$past(pend_q[3])) == 8'h00;
   endproperty
   a_no_pending: assert property (p_no_pending) else $error("repeat stored");

   property p_same_reg;
      @(posedge clk_in) disable iff (reset_in)
      (rd_in && acc_same && addr_in == `ADDR_FLAGS_BASE + 8'h03) |=>
         (flags_q[3] & $past(flags_q[3])) == $past(flags_q[3]);
   endproperty
   a_same_reg: assert property (p_same_reg) else $error("second access cleared");

   property p_new_source;
      @(posedge clk_in) disable iff (reset_in)
      (evm[1] & ~flags_q[1]) != 8'h00 |=>
         (flags_q[1] & $past(evm[1])) == $past(evm[1]);
   endproperty
   a_new_source: assert property (p_new_source) else $error("new event not flagged");

   property p_long_hold;
      @(posedge clk_in) disable iff (reset_in)
      (hold_hit && !mask_q[0][`G1_HOLD_BIT]) |=> flags_q[0][`G1_HOLD_BIT] ##1 hold_live;
   endproperty
   a_long_hold: assert property (p_long_hold) else $error("long hold not flagged");
endmodule

// ### host_bus_model.sv
`timescale 1ns/1ps
`include "pmic_irq_params.svh"
module host_bus_model (
   input wire logic clk_in,
   input wire logic [7:0] rdata_in,
   output logic [7:0] addr_out,
   output logic [7:0] wdata_out,
   output logic wr_out,
   output logic rd_out
);
   initial begin
      addr_out = 8'h00;
      wdata_out = 8'h00;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   // Idle bus shows the inverted address, and the inverted data after a write, so the device cannot lean on stale lines
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
      addr_out <= ~a;
      wdata_out <= ~d;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge clk_in);
      rd_out <= 1'b0;
      addr_out <= ~a;
      #1;
      d = rdata_in;
   endtask
   // sweep all groups
   // Starts on an unmapped address so the first clear never follows its own register
   task automatic sweep(input logic cow, output pmic_irq_pkg::byte_t f [4]);
      pmic_irq_pkg::byte_t junk;
      rd_reg(`ADDR_NONE, junk);
      for (int i = 0; i < 4; i++) begin
         if (cow) begin
            wr_reg(`ADDR_FLAGS_BASE + 8'(i), 8'hff);
            f[i] = 8'h00;
         end else begin
            rd_reg(`ADDR_FLAGS_BASE + 8'(i), f[i]);
         end
      end
   endtask
endmodule

// ### tb_pmic_interrupt_controller.sv
`timescale 1ns/1ps
`include "pmic_irq_params.svh"
module tb_pmic_interrupt_controller;
   logic clk_in, reset_in, wr, rd, irq, on_req;
   logic [7:0] addr, wdata, rdata, g3, gpio, prim;
   logic supply, die, pdown, btn_n, dev_on, sleep_st, shrt, first, rpin;
   int mismatches, num_checks;
   pmic_irq_pkg::byte_t v;
   pmic_irq_pkg::byte_t f [4];
   pmic_interrupt_controller #(.HOLD_BASE_CYCLES(20)) DUT (
      .clk_in(clk_in), .reset_in(reset_in), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .supply_monitor_event_in(supply),
      .die_overheat_event_in(die), .powerdown_pin_event_in(pdown),
      .power_button_n_in(btn_n), .device_on_in(dev_on), .sleep_state_in(sleep_st),
      .short_event_in(shrt), .first_supply_event_in(first), .reset_pin_event_in(rpin),
      .group_three_events_in(g3), .gpio_levels_in(gpio), .gpio_primary_in(prim),
      .irq_out(irq), .on_request_out(on_req));
   host_bus_model host (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
      .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input pmic_irq_pkg::byte_t got, input pmic_irq_pkg::byte_t exp,
                      input string msg);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic rdchk(input logic [7:0] a, input pmic_irq_pkg::byte_t exp, input string m);
      host.rd_reg(a, v);
      chk(v, exp, m);
   endtask
   task automatic rdf(input logic [7:0] g, input pmic_irq_pkg::byte_t exp);
      rdchk(`ADDR_FLAGS_BASE + g, exp, "flags");
   endtask
   task automatic t_reset();
      settle(8);
      chk({7'h00, irq}, 8'h01, "irq idle");
      chk({7'h00, on_req}, 8'h00, "on req");
      rdchk(`ADDR_MASKS_BASE, `RST_MASKS, "mask");
      rdchk(`ADDR_INT_CTRL, {5'h00, `RST_INT_CTRL}, "ctrl");
      rdchk(`ADDR_NONE, 8'h00, "unmapped");
   endtask
   task automatic t_supply();
      @(posedge clk_in) supply <= 1'b1;
      settle(6);
      chk({7'h00, irq}, 8'h00, "irq");
      chk({7'h00, on_req}, 8'h01, "on req");
      rdchk(`ADDR_LEVELS_BASE, 8'h40, "live");
      rdf(8'h00, 8'h40);
      rdf(8'h01, 8'h00);
      rdf(8'h00, 8'h00);
      settle(2);
      chk({7'h00, irq}, 8'h01, "irq");
   endtask
   task automatic t_mask();
      host.wr_reg(`ADDR_MASKS_BASE, 8'h40);
      @(posedge clk_in) supply <= 1'b0;
      settle(6);
      chk({7'h00, irq}, 8'h01, "masked irq");
      rdf(8'h00, 8'h00);
      host.wr_reg(`ADDR_MASKS_BASE, 8'h00);
      @(posedge clk_in) supply <= 1'b1;
      settle(6);
      host.wr_reg(`ADDR_MASKS_BASE, 8'h40);
      @(posedge clk_in) supply <= 1'b0;
      settle(6);
      chk({7'h00, irq}, 8'h00, "irq");
      rdf(8'h00, 8'h40);
      host.wr_reg(`ADDR_MASKS_BASE, 8'h00);
      settle(2);
      chk({7'h00, irq}, 8'h01, "irq");
   endtask
   task automatic t_repeat();
      @(posedge clk_in) die <= 1'b1;
      settle(6);
      @(posedge clk_in) pdown <= 1'b1;
      settle(6);
      @(posedge clk_in) die <= 1'b0;
      settle(6);
      rdf(8'h00, 8'h30);
      rdf(8'h01, 8'h00);
      rdf(8'h00, 8'h00);
      settle(2);
      chk({7'h00, irq}, 8'h01, "irq");
   endtask
   task automatic t_cow();
      host.wr_reg(`ADDR_INT_CTRL, 8'h02);
      @(posedge clk_in) {shrt, first, rpin, g3} <= {3'b111, 8'h01};
      settle(6);
      rdf(8'h01, 8'h70);
      rdf(8'h02, 8'h01);
      host.wr_reg(`ADDR_FLAGS_BASE + 8'h01, 8'h40);
      rdf(8'h02, 8'h01);
      rdf(8'h01, 8'h30);
      host.sweep(1'b1, f);
      settle(2);
      chk({7'h00, irq}, 8'h01, "irq");
      rdf(8'h01, 8'h00);
      @(posedge clk_in) {shrt, first, rpin, g3} <= 11'h000;
   endtask
   task automatic t_pending();
      host.wr_reg(`ADDR_INT_CTRL, 8'h04);
      host.wr_reg(`ADDR_RISE_EN, 8'h03);
      host.wr_reg(`ADDR_FALL_EN, 8'h04);
      @(posedge clk_in) gpio <= 8'h07;
      settle(6);
      @(posedge clk_in) gpio <= 8'h00;
      settle(6);
      @(posedge clk_in) gpio <= 8'h01;
      settle(6);
      chk({7'h00, irq}, 8'h00, "irq");
      rdf(8'h03, 8'h05);
      rdf(8'h03, 8'h01);
      rdf(8'h00, 8'h00);
      rdf(8'h03, 8'h01);
      rdf(8'h00, 8'h00);
      rdf(8'h03, 8'h00);
      settle(2);
      chk({7'h00, irq}, 8'h01, "irq");
   endtask
   task automatic t_sleep();
      host.wr_reg(`ADDR_INT_CTRL, 8'h01);
      settle(2);
      chk({7'h00, irq}, 8'h00, "high idle");
      host.wr_reg(`ADDR_SLEEP_CFG, 8'h01);
      @(posedge clk_in) {sleep_st, die} <= 2'b11;
      settle(6);
      chk({7'h00, irq}, 8'h00, "sleep irq");
      @(posedge clk_in) sleep_st <= 1'b0;
      settle(2);
      chk({7'h00, irq}, 8'h01, "awake irq");
      host.sweep(1'b0, f);
      chk(f[0], 8'h20, "sweep");
      settle(2);
      chk({7'h00, irq}, 8'h00, "irq");
      host.wr_reg(`ADDR_INT_CTRL, 8'h00);
      host.wr_reg(`ADDR_SLEEP_CFG, 8'h00);
   endtask
   task automatic t_hold();
      @(posedge clk_in) {dev_on, btn_n} <= 2'b10;
      settle(30);
      chk({7'h00, on_req}, 8'h01, "on req");
      rdf(8'h00, 8'h06);
      @(posedge clk_in) btn_n <= 1'b1;
      host.wr_reg(`ADDR_HOLD_DELAY, 8'h01);
      @(posedge clk_in) btn_n <= 1'b0;
      settle(30);
      rdf(8'h01, 8'h00);
      rdf(8'h00, 8'h02);
      settle(20);
      rdf(8'h01, 8'h00);
      rdf(8'h00, 8'h04);
      @(posedge clk_in) {dev_on, btn_n} <= 2'b01;
      host.wr_reg(`ADDR_MASKS_BASE, 8'h02);
      @(posedge clk_in) btn_n <= 1'b0;
      settle(8);
      chk({7'h00, on_req}, 8'h01, "masked btn");
      @(posedge clk_in) btn_n <= 1'b1;
      settle(6);
      rdf(8'h00, 8'h00);
      // Unmasked press while off must still leave the flag clear
      host.wr_reg(`ADDR_MASKS_BASE, 8'h00);
      @(posedge clk_in) btn_n <= 1'b0;
      settle(8);
      @(posedge clk_in) btn_n <= 1'b1;
      settle(6);
      rdf(8'h00, 8'h00);
      settle(2);
      chk({7'h00, on_req}, 8'h00, "on req");
   endtask
   initial begin
      #100us;
      mismatches++;
      summarize();
   end
   initial begin
      mismatches = 0;
      num_checks = 0;
      reset_in = 1'b1;
      {supply, die, pdown, dev_on, sleep_st, shrt, first, rpin} = 8'h00;
      btn_n = 1'b1;
      g3 = 8'h00;
      gpio = 8'h00;
      prim = 8'hfd;
      repeat (5) @(posedge clk_in);
      reset_in <= 1'b0;
      t_reset();
      t_supply();
      t_mask();
      t_repeat();
      t_cow();
      t_pending();
      t_sleep();
      t_hold();
      summarize();
   end
endmodule
